/* File: vtpr_pkg.sv */
package vtpr_pkg;
    localparam int VA_W        = 16;
    localparam int PA_W        = 22;
    localparam int PAGE_SEL_HI = 15;
    localparam int PAGE_SEL_LO = 13;
    localparam int BLK_HI      = 12;
    localparam int BLK_LO      = 6;
    localparam int OFS_HI      = 5;
    localparam int BASE_W      = 16;
    localparam int BASE18_W    = 12;
    localparam int PLL_W       = 7;
    localparam int NPAGE       = 8;
    localparam int PAIR_IDX_W  = 4;
    localparam int EXT_CTL_22B = 4;
    localparam int CSR_RELOC   = 0;
    localparam int BANK_HI     = 21;
    localparam int BANK_LO     = 18;
    localparam int TAG_HI      = 17;
    localparam int TAG_LO      = 13;
    localparam int IO_FORCE_LO = 16;
    localparam int PER_W       = 18;
    localparam logic [15:0] BASE18_MASK   = 16'h0fff;
    localparam logic [5:0]  IO_FORCE_ONES = 6'h3f;
    localparam logic [1:0]  STRAP_RESET   = 2'h3;
    localparam logic [4:0]  IO_PAGE_TAG  = 5'h1f;
    localparam logic [3:0]  BANK_ONES    = 4'hf;
    localparam logic [3:0]  BANK_ZERO    = 4'h0;
    localparam logic [2:0]  VA_TOP_PAGE  = 3'h7;
    localparam logic [21:0] PA_RESET     = 22'h000000;
endpackage : vtpr_pkg

/* File: vtpr_page_mem.sv */
`timescale 1ns/1ns
// ------------------------------------------------------------
// Page register pair store, registered read
// ------------------------------------------------------------
module vtpr_page_mem
    import vtpr_pkg::*;
#(
    parameter int BW = BASE_W,
    parameter int LW = PLL_W,
    parameter int AW = PAIR_IDX_W
)(
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_idx,
    input  wire logic [BW-1:0] wr_base,
    input  wire logic [LW-1:0] wr_limit,
    input  wire logic [AW-1:0] rd_idx,
    output logic      [BW-1:0] rd_base,
    output logic      [LW-1:0] rd_limit
);
    logic [BW-1:0] base_mem  [2**AW];
    logic [LW-1:0] limit_mem [2**AW];

    always_ff @(posedge clk)
    begin
        if (wr_en)
        begin
            base_mem[wr_idx]  <= wr_base;
            limit_mem[wr_idx] <= wr_limit;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_base  <= '0;
            rd_limit <= '0;
        end
        else
        begin
            rd_base  <= base_mem[rd_idx];
            rd_limit <= limit_mem[rd_idx];
        end
    end
endmodule : vtpr_page_mem

/* File: vtpr_relocate.sv */
`timescale 1ns/1ns
module vtpr_relocate
    import vtpr_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst_b,
    // Page register load port
    input  wire logic                  pair_wr_en,
    input  wire logic                  pair_wr_user,
    input  wire logic [2:0]            pair_wr_page,
    input  wire logic [BASE_W-1:0]     pair_wr_base,
    input  wire logic [PLL_W-1:0]      pair_wr_limit,
    // Control bits
    input  wire logic [15:0]           mmu_control_status,
    input  wire logic [15:0]           mmu_extended_control,
    input  wire logic                  compatibility_strap,
    // Processor request
    input  wire logic                  va_valid,
    input  wire logic                  va_user_mode,
    input  wire logic [VA_W-1:0]       va_addr,
    // Results
    output logic                       pa_valid,
    output logic [PA_W-1:0]            extended_physical_address_bus,
    output logic                       io_bank_select,
    output logic                       mem_bus_sel,
    output logic                       periph_bus_sel,
    output logic [17:0]                periph_addr,
    output logic                       length_over
);
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        VTPR_IDLE = 2'b01,
        VTPR_MAP  = 2'b10
    } vtpr_state_t;

    typedef struct packed {
        vtpr_state_t       st;
        logic [1:0]        strap_sync;
        logic [VA_W-1:0]   va;
        logic              valid;
        logic [PA_W-1:0]   pa;
        logic              io_sel;
        logic              mem_sel;
        logic              per_sel;
        logic [17:0]       per_addr;
        logic              over;
    } vtpr_regs_t;

    // Translated address with its io page flag
    typedef struct packed {
        logic [PA_W-1:0]   pa;
        logic              io;
    } vtpr_map_t;

    // Mapping mode as decoded from the two control bits
    typedef enum logic [2:0] {
        VTPR_FLAT  = 3'b001,
        VTPR_MAP18 = 3'b010,
        VTPR_MAP22 = 3'b100
    } vtpr_mode_t;

    vtpr_regs_t r, nxt;
    logic [BASE_W-1:0] base_rd;
    logic [PLL_W-1:0]  limit_rd;
    logic              rst_n;

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic [1:0] rst_pipe_r;
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            rst_pipe_r <= 2'h0;
        else
            rst_pipe_r <= {rst_pipe_r[0], 1'b1};
    end
    assign rst_n = rst_pipe_r[1];

    // ------------------------------------------------------------
    // Page register pairs
    // ------------------------------------------------------------
    vtpr_page_mem #(
        .BW (BASE_W),
        .LW (PLL_W),
        .AW (PAIR_IDX_W)
    ) vtpr_page_mem_inst (
        .clk      (clk),
        .rst_n    (rst_n),
        .wr_en    (pair_wr_en),
        .wr_idx   ({pair_wr_user, pair_wr_page}),
        .wr_base  (pair_wr_base),
        .wr_limit (pair_wr_limit),
        .rd_idx   ({va_user_mode, va_addr[PAGE_SEL_HI:PAGE_SEL_LO]}),
        .rd_base  (base_rd),
        .rd_limit (limit_rd)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [PA_W-1:0] relocate(
        input logic [BASE_W-1:0] base,
        input logic [VA_W-1:0]   va,
        input logic              wide
    );
        logic [BASE_W-1:0] eff_base;
        logic [BASE_W-1:0] physical_block_number;
        // Upper base bits stay stored, only the adder sees them masked
        eff_base = wide ? base : (base & BASE18_MASK);
        // Sum width is the field width, so carry out drops
        physical_block_number = eff_base + BASE_W'(va[BLK_HI:BLK_LO]);
        return {physical_block_number, va[OFS_HI:0]};
    endfunction : relocate

    function automatic logic in_top_128kw(input logic [PA_W-1:0] pa);
        return pa[BANK_HI:BANK_LO] == BANK_ONES;
    endfunction : in_top_128kw

    function automatic logic in_io_page(input logic [PA_W-1:0] pa);
        return in_top_128kw(pa) && (pa[TAG_HI:TAG_LO] == IO_PAGE_TAG);
    endfunction : in_io_page

    // Relocation enable outranks the width bit
    function automatic vtpr_mode_t mode_of(
        input logic [15:0] csr,
        input logic [15:0] ext
    );
        if (!csr[CSR_RELOC])
        begin
            return VTPR_FLAT;
        end
        if (ext[EXT_CTL_22B])
        begin
            return VTPR_MAP22;
        end
        return VTPR_MAP18;
    endfunction : mode_of

    // Relocation off: flat pass, top virtual page moved to the io page
    function automatic vtpr_map_t map_flat(input logic [VA_W-1:0] va);
        vtpr_map_t m;
        m.pa = PA_W'(va);
        m.io = (va[PAGE_SEL_HI:PAGE_SEL_LO] == VA_TOP_PAGE);
        if (m.io)
        begin
            m.pa[BANK_HI:IO_FORCE_LO] = IO_FORCE_ONES;
        end
        return m;
    endfunction : map_flat

    // 18-bit: bank bits follow the io tag, never the adder
    function automatic vtpr_map_t map_18(input logic [PA_W-1:0] sum);
        vtpr_map_t m;
        m.pa = sum;
        m.io = (sum[TAG_HI:TAG_LO] == IO_PAGE_TAG);
        m.pa[BANK_HI:BANK_LO] = m.io ? BANK_ONES : BANK_ZERO;
        return m;
    endfunction : map_18

    // 22-bit: the io page is reached by plain arithmetic only
    function automatic vtpr_map_t map_22(input logic [PA_W-1:0] sum);
        vtpr_map_t m;
        m.pa = sum;
        m.io = in_io_page(sum);
        return m;
    endfunction : map_22

    // Plain greater-than: pages grow upward only
    function automatic logic beyond_limit(
        input logic [VA_W-1:0]  va,
        input logic [PLL_W-1:0] limit
    );
        return va[BLK_HI:BLK_LO] > limit;
    endfunction : beyond_limit

    // Memory bus takes all but the peripheral window, io page included
    function automatic logic to_mem_bus(input logic [PA_W-1:0] pa);
        return !in_top_128kw(pa) || in_io_page(pa);
    endfunction : to_mem_bus

    // Open strap mirrors all traffic, so 22-bit use aliases low addresses
    function automatic logic to_periph_bus(
        input logic [PA_W-1:0] pa,
        input logic            compat
    );
        return in_top_128kw(pa) || compat;
    endfunction : to_periph_bus

    // ------------------------------------------------------------
    // Translation
    // ------------------------------------------------------------
    vtpr_mode_t mode;
    logic       reloc_on;
    logic       wide_map;
    logic       compat;
    assign mode     = mode_of(mmu_control_status, mmu_extended_control);
    assign reloc_on = (mode != VTPR_FLAT);
    assign wide_map = (mode == VTPR_MAP22);
    // Strap is a pin, read only behind its second flop
    assign compat   = !r.strap_sync[1];

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic [PA_W-1:0] sum;
        vtpr_map_t       m;
        sum = relocate(base_rd, r.va, wide_map);
        m   = map_flat(r.va);
        nxt = r;
        nxt.strap_sync = {r.strap_sync[0], compatibility_strap};
        nxt.valid      = 1'b0;
        unique case (r.st)
            VTPR_IDLE:
            begin
                if (va_valid)
                begin
                    nxt.va = va_addr;
                    nxt.st = VTPR_MAP;
                end
            end
            VTPR_MAP:
            begin
                // Pair memory already holds the pair of the taken address
                unique case (mode)
                    VTPR_FLAT:  m = map_flat(r.va);
                    VTPR_MAP18: m = map_18(sum);
                    VTPR_MAP22: m = map_22(sum);
                endcase
                nxt.pa       = m.pa;
                nxt.io_sel   = m.io;
                nxt.over     = reloc_on && beyond_limit(r.va, limit_rd);
                // Steering
                nxt.per_sel  = to_periph_bus(m.pa, compat);
                nxt.mem_sel  = to_mem_bus(m.pa);
                nxt.per_addr = m.pa[PER_W-1:0];
                nxt.valid    = 1'b1;
                nxt.st       = VTPR_IDLE;
            end
            default:
                nxt.st = VTPR_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r.st         <= VTPR_IDLE;
            r.strap_sync <= STRAP_RESET;
            r.va       <= '0;
            r.valid    <= 1'b0;
            r.pa       <= PA_RESET;
            r.io_sel   <= 1'b0;
            r.mem_sel  <= 1'b0;
            r.per_sel  <= 1'b0;
            r.per_addr <= '0;
            r.over     <= 1'b0;
        end
        else
            r <= nxt;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign pa_valid                      = r.valid;
    assign extended_physical_address_bus = r.pa;
    assign io_bank_select                = r.io_sel;
    assign mem_bus_sel                   = r.mem_sel;
    assign periph_bus_sel                = r.per_sel;
    assign periph_addr                   = r.per_addr;
    assign length_over                   = r.over;
endmodule : vtpr_relocate

/* File: vtpr_chk_assertions.sv */
`timescale 1ns/1ns
module vtpr_chk
    import vtpr_pkg::*;
(
    input wire logic            clk,
    input wire logic            rst_b,
    input wire logic [15:0]     mmu_control_status,
    input wire logic [15:0]     mmu_extended_control,
    input wire logic            compatibility_strap,
    input wire logic [VA_W-1:0] va_addr,
    input wire logic            pa_valid,
    input wire logic [PA_W-1:0] extended_physical_address_bus,
    input wire logic            io_bank_select,
    input wire logic            mem_bus_sel,
    input wire logic            periph_bus_sel,
    input wire logic [17:0]     periph_addr,
    input wire logic            length_over
);
    logic [PA_W-1:0] pa;
    logic            top;
    logic            io4;
    assign pa  = extended_physical_address_bus;
    assign top = pa[21:18] == 4'hf;
    assign io4 = pa[21:13] == 9'h1ff;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_low_bits: assert property (pa_valid |-> pa[5:0] == $past(va_addr[5:0]))
        else $error("offset bits altered");
    a_periph_addr: assert property (pa_valid |-> periph_addr == pa[17:0])
        else $error("peripheral address not truncated");
    a_io_both: assert property (pa_valid && io4 |-> mem_bus_sel && periph_bus_sel)
        else $error("io page not on both buses");
    a_below_mem: assert property (
        pa_valid && !top && compatibility_strap |-> mem_bus_sel && !periph_bus_sel)
        else $error("low address misrouted");
    a_window_skip: assert property (
        pa_valid && top && !io4 |-> !mem_bus_sel && periph_bus_sel)
        else $error("window address reached memory");
    a_compat_periph: assert property (
        pa_valid && !compatibility_strap |-> periph_bus_sel)
        else $error("compatibility ref not on peripheral bus");
    a_bank_18: assert property (
        pa_valid && $past(mmu_control_status[0]) && !$past(mmu_extended_control[4])
        |-> io_bank_select == (pa[17:13] == 5'h1f) && pa[21:18] == {4{io_bank_select}})
        else $error("18-bit bank forcing wrong");
    a_io_tag: assert property (pa_valid && io_bank_select |-> pa[21:13] == 9'h1ff)
        else $error("io select outside io page");
    a_pulse_once: assert property (pa_valid |=> !pa_valid)
        else $error("answer pulse too long");
    a_hold_pa: assert property (!pa_valid |-> $stable(pa))
        else $error("address moved between answers");
    c_io: cover property (pa_valid && io_bank_select);
    c_compat: cover property (pa_valid && !compatibility_strap);
    c_window: cover property (pa_valid && !mem_bus_sel);
    c_over: cover property (pa_valid && length_over);
endmodule : vtpr_chk
bind vtpr_relocate vtpr_chk vtpr_chk_inst (.clk, .rst_b, .mmu_control_status,
    .mmu_extended_control, .compatibility_strap, .va_addr, .pa_valid,
    .extended_physical_address_bus, .io_bank_select, .mem_bus_sel, .periph_bus_sel,
    .periph_addr, .length_over);

/* File: vtpr_cpu_model.sv */
`timescale 1ns/1ns
module vtpr_cpu_model
    import vtpr_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            pa_valid,
    output logic                 va_valid,
    output logic                 va_user_mode,
    output logic [VA_W-1:0]      va_addr
);
    initial
    begin
        va_valid     = 1'b0;
        va_user_mode = 1'b0;
        va_addr      = 16'h0000;
    end
    // -------------------------------
    // Request, gap makes it prompt or slow
    // -------------------------------
    task automatic req(input logic [15:0] va, input logic usr, input int gap, output logic ok);
        ok = 1'b0;
        repeat (gap + 1) @(posedge clk);
        va_valid     <= 1'b1;
        va_addr      <= va;
        va_user_mode <= usr;
        @(posedge clk);
        va_valid <= 1'b0;
        for (int i = 0; i < 8 && !ok; i++)
        begin
            @(posedge clk);
            #1 ok = pa_valid;
        end
        // Stale address must not look valid
        @(posedge clk);
        va_addr <= ~va;
    endtask : req
endmodule : vtpr_cpu_model

/* File: vtpr_relocate_tb.sv */
`timescale 1ns/1ns
module vtpr_relocate_tb;
    import vtpr_pkg::*;
    logic        clk, rst_b, pair_wr_en, pair_wr_user, compatibility_strap, ok, s;
    logic        va_valid, va_user_mode, pa_valid, io_bank_select, mem_bus_sel;
    logic        periph_bus_sel, length_over;
    logic [2:0]  pair_wr_page;
    logic [6:0]  pair_wr_limit;
    logic [15:0] pair_wr_base, mmu_control_status, mmu_extended_control, va_addr;
    logic [21:0] extended_physical_address_bus;
    logic [17:0] periph_addr;
    logic [15:0] base_m [16];
    logic [6:0]  lim_m [16];
    logic [16:0] cv [5] = '{17'h01fff, 17'h13fff, 17'h05fff, 17'h06005, 17'h0e123};
    int          bad_count, n_tests;
    vtpr_relocate vtpr_relocate_inst (.clk, .rst_b, .pair_wr_en, .pair_wr_user, .pair_wr_page,
        .pair_wr_base, .pair_wr_limit, .mmu_control_status, .mmu_extended_control,
        .compatibility_strap, .va_valid, .va_user_mode, .va_addr, .pa_valid,
        .extended_physical_address_bus, .io_bank_select, .mem_bus_sel, .periph_bus_sel,
        .periph_addr, .length_over);
    vtpr_cpu_model vtpr_cpu_model_inst (.clk, .pa_valid, .va_valid, .va_user_mode, .va_addr);
    always #5 clk = ~clk;
    // -------------------------------
    // Reference model and checks
    // -------------------------------
    function automatic logic [25:0] model(input logic [15:0] b, input logic [6:0] l,
        input logic [15:0] va, input logic rel, wide, strap);
        logic [15:0] physical_block_number;
        logic [21:0] pa;
        logic        io;
        physical_block_number = (wide ? b : {4'h0, b[11:0]}) + {9'h000, va[12:6]};
        pa = {physical_block_number, va[5:0]};
        io = wide ? pa[21:13] == 9'h1ff : pa[17:13] == 5'h1f;
        if (!wide) pa[21:18] = {4{io}};
        if (!rel)
        begin
            io = va[15:13] == 3'h7;
            pa = {{6{io}}, va};
        end
        return {pa, io, pa[21:18] != 4'hf || pa[21:13] == 9'h1ff,
            pa[21:18] == 4'hf || !strap, rel && va[12:6] > l};
    endfunction : model
    task automatic chk(input string nm, input logic [21:0] e, input logic [21:0] g);
        n_tests++;
        if (g !== e)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wrap_up;
        if (bad_count == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : wrap_up
    task automatic wr(input logic [3:0] ix, input logic [15:0] b, input logic [6:0] l);
        @(posedge clk);
        pair_wr_en <= 1'b1;
        {pair_wr_user, pair_wr_page} <= ix;
        pair_wr_base <= b;
        pair_wr_limit <= l;
        base_m[ix] = b;
        lim_m[ix] = l;
        @(posedge clk);
        pair_wr_en <= 1'b0;
    endtask : wr
    task automatic run(input logic [15:0] va, input logic u, rel, wide, strap, input int gap);
        logic [25:0] e;
        @(posedge clk);
        mmu_control_status <= {15'($urandom), rel};
        mmu_extended_control <= {11'($urandom), wide, 4'($urandom)};
        compatibility_strap <= strap;
        e = model(base_m[{u, va[15:13]}], lim_m[{u, va[15:13]}], va, rel, wide, strap);
        vtpr_cpu_model_inst.req(va, u, gap, ok);
        if (!ok)
        begin
            bad_count++;
            wrap_up();
        end
        else
        begin
            chk("pa", e[25:4], extended_physical_address_bus);
            chk("flags", {18'h0, e[3:0]},
                {18'h0, io_bank_select, mem_bus_sel, periph_bus_sel, length_over});
            chk("periph", {4'h0, e[21:4]}, {4'h0, periph_addr});
        end
    endtask : run
    initial
    begin
        {clk, rst_b, pair_wr_en, pair_wr_user, pair_wr_page, pair_wr_base, pair_wr_limit} = '0;
        {mmu_control_status, mmu_extended_control} = '0;
        compatibility_strap = 1'b1;
        void'($urandom(96049));
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 16; i++) wr(4'(i), 16'($urandom), 7'($urandom));
        wr(4'h0, 16'hffff, 7'h00);
        wr(4'h9, 16'h5f80, 7'h7f);
        wr(4'h2, 16'hff80, 7'h40);
        wr(4'h3, 16'hf800, 7'h00);
        // Wide mapping only with strap closed
        foreach (cv[k])
            for (int m = 0; m < 6; m++)
                run(cv[k][15:0], cv[k][16], m % 3 != 0, m == 5, m > 2, k);
        for (int n = 0; n < 300; n++)
        begin
            if ($urandom % 8 == 0) wr(4'($urandom), 16'($urandom), 7'($urandom));
            s = $urandom % 4 != 0;
            run(16'($urandom), 1'($urandom), $urandom % 4 != 0, s & 1'($urandom), s,
                $urandom % 3);
        end
        wrap_up();
    end
endmodule : vtpr_relocate_tb
